// >>> bench/able_exec_tb_top.sv
/*
 Self-checking bench for the bit-logic execution datapath.
 Assumes the bench stands in for fetch and file memory; file data answers at once.
*/
`timescale 1ns/10ps
`default_nettype none
module able_exec_tb_top;
   import able_pkg::*;
   logic clk = 1'b0; // Core clock
   logic reset_n = 1'b0; // Held low at start
   logic [15:0] instr = 16'h0000; // Word offered at Q1
   logic [7:0] fval = 8'h00; // File byte, same for any address
   logic [7:0] file_addr;
   able_fwr_s file_wr;
   logic [7:0] working_accumulator;
   logic [3:0] flags;
   able_phase_e phase;
   logic skip_cycle;
   logic instr_done;
   logic [7:0] m_acc = 8'h00; // Expected accumulator
   logic [3:0] m_flg = 4'h0; // Expected flags
   int n_mismatch = 0;
   int n_checks = 0;

   // Free-running 100 MHz clock
   always #5 clk = ~clk;

   able_exec dut_u (.clk(clk), .reset_n(reset_n), .instr(instr), .file_addr(file_addr),
      .file_rdata(fval), .file_wr(file_wr), .working_accumulator(working_accumulator),
      .flags(flags), .phase(phase), .skip_cycle(skip_cycle), .instr_done(instr_done));

   // Verdict and end of run
   task automatic wrap_up;
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // One comparison, four-state exact
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Issue one word at Q1 and judge the cycle that follows
   task automatic op(input logic [15:0] w, input logic [7:0] fv, input logic ew,
                     input logic [7:0] ed, input logic [7:0] ea, input logic [3:0] ef,
                     input logic esk);
      int i;
      for (i = 0; i < 8 && phase !== ABLE_Q1; i++) begin
         @(posedge clk);
         #1;
      end
      if (phase !== ABLE_Q1) begin
         n_mismatch++;
         wrap_up();
      end
      instr = w;
      fval = fv;
      @(posedge clk);
      #1;
      chk(phase, ABLE_Q2);
      chk(skip_cycle, esk);
      if (!esk) chk(file_addr, w[7:0]);
      repeat (3) begin
         @(posedge clk);
         #1;
      end
      // Results land on the edge leaving Q4
      chk(file_wr.we, ew);
      if (ew) chk({file_wr.addr, file_wr.data}, {w[7:0], ed});
      chk(instr_done, 1'b1);
      chk(working_accumulator, ea);
      chk(flags, ef);
      m_acc = ea;
      m_flg = ef;
   endtask

   // Add with carry; expected sum and flags worked out here
   task automatic addc(input logic d, input logic [7:0] fv);
      logic [8:0] s;
      logic [4:0] h;
      logic [3:0] nf;
      s = {1'b0, m_acc} + {1'b0, fv} + {8'h00, m_flg[FLG_C]};
      h = {1'b0, m_acc[3:0]} + {1'b0, fv[3:0]} + {4'h0, m_flg[FLG_C]};
      nf[FLG_C] = s[8];
      nf[FLG_DC] = h[4];
      nf[FLG_Z] = (s[7:0] == 8'h00);
      nf[FLG_OV] = (m_acc[7] == fv[7]) && (s[7] != m_acc[7]);
      op({PAT_ADDC, d, 8'h21}, fv, d, s[7:0], d ? m_acc : s[7:0], nf, 1'b0);
   endtask

   // Carry chains, signed overflow, zero and both destinations
   task automatic s_addc;
      addc(1'b0, 8'hff);
      addc(1'b0, 8'h01);
      addc(1'b1, 8'h7f);
      addc(1'b0, 8'h80);
      addc(1'b0, 8'h80);
      addc(1'b0, 8'h4d);
   endtask

   // Both AND forms; only the zero flag may move
   task automatic andx(input logic [15:0] w, input logic [7:0] fv, input logic tof);
      logic [7:0] r;
      logic [3:0] nf;
      r = m_acc & ((w[15:8] == PAT_ANDL) ? w[7:0] : fv);
      nf = m_flg;
      nf[FLG_Z] = (r == 8'h00);
      op(w, fv, tof, r, tof ? m_acc : r, nf, 1'b0);
   endtask

   // Carry and nibble carry are set first, so the ANDs must keep them
   task automatic s_and;
      addc(1'b0, 8'hcf);
      andx({PAT_ANDF, 1'b1, 8'h44}, 8'hc2, 1'b1);
      andx({PAT_ANDF, 1'b0, 8'h45}, 8'h17, 1'b0);
      andx({PAT_ANDL, 8'h5f}, 8'h00, 1'b0);
      andx({PAT_ANDL, 8'h00}, 8'hff, 1'b0);
   endtask

   // Every bit position cleared and set; flags and accumulator kept
   task automatic s_bits;
      logic [7:0] msk;
      for (int b = 0; b < 8; b++) begin
         msk = 8'h01 << b;
         op({PAT_BCLR, b[2:0], 8'h30}, 8'hff, 1'b1, ~msk, m_acc, m_flg, 1'b0);
         op({PAT_BSET, b[2:0], 8'h31}, 8'h00, 1'b1, msk, m_acc, m_flg, 1'b0);
      end
   endtask

   // Bit clear skips the next word; bit set lets it run
   task automatic s_skip;
      op({PAT_BTSZ, 3'h1, 8'h50}, 8'hfd, 1'b0, 8'h00, m_acc, m_flg, 1'b0);
      op({PAT_ADDC, 1'b0, 8'h51}, 8'h55, 1'b0, 8'h00, m_acc, m_flg, 1'b1);
      op({PAT_BSET, 3'h0, 8'h52}, 8'h00, 1'b1, 8'h01, m_acc, m_flg, 1'b0);
      op({PAT_BTSZ, 3'h7, 8'h53}, 8'h00, 1'b0, 8'h00, m_acc, m_flg, 1'b0);
      op({PAT_BSET, 3'h2, 8'h54}, 8'h00, 1'b0, 8'h00, m_acc, m_flg, 1'b1);
      op({PAT_BTSZ, 3'h1, 8'h55}, 8'h02, 1'b0, 8'h00, m_acc, m_flg, 1'b0);
      op({PAT_BSET, 3'h3, 8'h56}, 8'h00, 1'b1, 8'h08, m_acc, m_flg, 1'b0);
      // Near misses of the add and file AND patterns must do nothing
      op(16'h1321, 8'h5a, 1'b0, 8'h00, m_acc, m_flg, 1'b0);
      op(16'h0e21, 8'h5a, 1'b0, 8'h00, m_acc, m_flg, 1'b0);
   endtask

   // Reset values while reset is held, then release just after an edge
   task automatic s_reset;
      repeat (8) @(posedge clk);
      #1;
      chk({phase, working_accumulator, flags}, {ABLE_Q1, ACC_RST, FLG_RST});
      chk({file_wr.we, skip_cycle, instr_done}, 3'h0);
      reset_n = 1'b1;
   endtask

   // Main sequence: reset for 8 cycles, then each scenario back to back
   initial begin
      s_reset();
      s_addc();
      s_and();
      s_bits();
      s_skip();
      wrap_up();
   end
endmodule // able_exec_tb_top
`default_nettype wire

// >>> include/able_pkg.sv
/*
 Package for the bit-logic execution datapath: opcode patterns, flag
 layout, phase enumeration and the packed carriers used at its ports.
 Assumes a core that presents one 16-bit instruction word per cycle.
*/
//
// Contract
// - Decode pattern adds acc, carry, file
// - Add result: d=0 accumulator, d=1 file
// - Add updates overflow, carry, nibble carry, zero
// - Literal AND into accumulator, zero only
// - File AND with accumulator, zero only
// - File AND: d=0 accumulator, d=1 file
// - Bit clear in file, flags kept
// - Bit set in file, flags kept
// - Bit test skips next when zero
// - Skip discards fetched word, two cycles
// - Skip cycle writes nothing anywhere
package able_pkg;
   // Opcode fields
   localparam int OPC_HI = 15;
   localparam int OPC7_LO = 9;
   localparam int OPC8_LO = 8;
   localparam int OPC5_LO = 11;
   localparam int DEST_BIT = 8;
   localparam int BSEL_LO = 8;
   localparam logic [6:0] PAT_ADDC = 7'h08;   // 0001 000d
   localparam logic [6:0] PAT_ANDF = 7'h05;   // 0000 101d
   localparam logic [7:0] PAT_ANDL = 8'hb5;   // 1011 0101
   localparam logic [4:0] PAT_BCLR = 5'h11;   // 1000 1bbb
   localparam logic [4:0] PAT_BSET = 5'h10;   // 1000 0bbb
   localparam logic [4:0] PAT_BTSZ = 5'h13;   // 1001 1bbb
   // Flag positions inside the four-bit status field
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] FLG_RST = 4'h0;

   typedef enum logic [1:0] {ABLE_Q1, ABLE_Q2, ABLE_Q3, ABLE_Q4} able_phase_e;

   // Operation selected by decode
   typedef enum logic [2:0] {
      ABLE_OP_NONE, ABLE_OP_ADDC, ABLE_OP_ANDL, ABLE_OP_ANDF,
      ABLE_OP_BCLR, ABLE_OP_BSET, ABLE_OP_BTSZ
   } able_op_e;

   // File register write request
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } able_fwr_s;
endpackage

// >>> verilog/able_exec.sv
/*
 Execution datapath for six instructions of an 8-bit core, stepped
 through a four-phase instruction cycle. Holds the accumulator and the
 four status flags. Assumes the fetch logic offers instr at Q1, file
 data returns combinationally from file_rdata for file_addr, and that
 the fetcher watches skip_cycle to hold its program counter. A skipped
 word is still latched here but decoded as a no-op, so the fetcher need
 not replace it. There is no stall input: every instruction takes four clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module able_exec (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [15:0] instr,
   output logic [7:0] file_addr,
   input wire logic [7:0] file_rdata,
   output able_pkg::able_fwr_s file_wr,
   output logic [7:0] working_accumulator,
   output logic [3:0] flags,
   output able_pkg::able_phase_e phase,
   output logic skip_cycle,
   output logic instr_done
);
   import able_pkg::*;

   // Sequencing and datapath state; every register shares the one reset
   able_phase_e phase_reg, phase_next;   // Q-phase counter
   able_op_e op_reg, op_next;            // Decoded operation
   logic [15:0] ir_reg, ir_next;         // Latched instruction word
   logic [7:0] opnd_reg, opnd_next;      // Operand read in Q2
   logic [8:0] res_reg, res_next;        // Result plus carry out
   logic [3:0] flg_res_reg, flg_res_next; // Flags computed in Q3, applied in Q4
   logic [7:0] acc_reg, acc_next;        // Working accumulator
   logic [3:0] flg_reg, flg_next;        // Status flags seen by software
   logic skip_pend_reg, skip_pend_next;  // Next cycle becomes forced no-op
   logic skip_reg, skip_next;            // Current cycle is forced no-op
   able_fwr_s fwr_reg, fwr_next;
   logic done_reg, done_next;
   logic [4:0] nib;                      // Nibble sum for digit carry
   logic [7:0] bmask;                    // One-hot bit select

   // Decode a fresh word into an operation
   // Patterns do not overlap, so the order of the tests is free
   function automatic able_op_e decode(input logic [15:0] w);
      if (w[OPC_HI:OPC7_LO] == PAT_ADDC) return ABLE_OP_ADDC;
      if (w[OPC_HI:OPC8_LO] == PAT_ANDL) return ABLE_OP_ANDL;
      if (w[OPC_HI:OPC7_LO] == PAT_ANDF) return ABLE_OP_ANDF;
      if (w[OPC_HI:OPC5_LO] == PAT_BCLR) return ABLE_OP_BCLR;
      if (w[OPC_HI:OPC5_LO] == PAT_BSET) return ABLE_OP_BSET;
      if (w[OPC_HI:OPC5_LO] == PAT_BTSZ) return ABLE_OP_BTSZ;
      return ABLE_OP_NONE;
   endfunction

   // Mask and file address come from the latched word, stable from Q2 to Q1
   assign bmask = 8'h01 << ir_reg[BSEL_LO +: 3];
   assign file_addr = ir_reg[7:0];

   // Phase sequencing, decode, execute and write-back
   always_comb begin
      phase_next = phase_reg;
      op_next = op_reg;
      ir_next = ir_reg;
      opnd_next = opnd_reg;
      res_next = res_reg;
      flg_res_next = flg_res_reg;
      acc_next = acc_reg;
      flg_next = flg_reg;
      skip_pend_next = skip_pend_reg;
      skip_next = skip_reg;
      fwr_next = '0;
      done_next = 1'b0;
      nib = 5'h00;
      unique case (phase_reg)
         ABLE_Q1: begin
            // Decode; a pending skip forces the fetched word to no-op
            phase_next = ABLE_Q2;
            ir_next = instr;
            skip_next = skip_pend_reg;
            skip_pend_next = 1'b0;
            op_next = skip_pend_reg ? ABLE_OP_NONE : decode(instr);
         end
         ABLE_Q2: begin
            // Operand read: literal for the immediate AND, else the file
            phase_next = ABLE_Q3;
            opnd_next = (op_reg == ABLE_OP_ANDL) ? ir_reg[7:0] : file_rdata;
         end
         ABLE_Q3: begin
            // Execute
            phase_next = ABLE_Q4;
            flg_res_next = flg_reg;
            res_next = {1'b0, opnd_reg};
            unique case (op_reg)
               ABLE_OP_ADDC: begin
                  res_next = {1'b0, acc_reg} + {1'b0, opnd_reg}
                     + {8'h00, flg_reg[FLG_C]};
                  nib = {1'b0, acc_reg[3:0]} + {1'b0, opnd_reg[3:0]}
                     + {4'h0, flg_reg[FLG_C]};
                  flg_res_next[FLG_C] = res_next[8];
                  flg_res_next[FLG_DC] = nib[4];
                  flg_res_next[FLG_Z] = (res_next[7:0] == 8'h00);
                  // Signed overflow: like signs in, unlike sign out
                  flg_res_next[FLG_OV] = (acc_reg[7] == opnd_reg[7])
                     && (res_next[7] != acc_reg[7]);
               end
               ABLE_OP_ANDL, ABLE_OP_ANDF: begin
                  // Carry, nibble carry and overflow keep their old values
                  res_next = {1'b0, acc_reg & opnd_reg};
                  flg_res_next[FLG_Z] = ((acc_reg & opnd_reg) == 8'h00);
               end
               // Bit ops touch only the selected bit; flags stay as they were
               ABLE_OP_BCLR: res_next = {1'b0, opnd_reg & ~bmask};
               ABLE_OP_BSET: res_next = {1'b0, opnd_reg | bmask};
               // Only arm the skip here; the forced no-op starts at the next decode
               ABLE_OP_BTSZ: skip_pend_next = ((opnd_reg & bmask) == 8'h00);
               ABLE_OP_NONE: ;
            endcase
         end
         ABLE_Q4: begin
            // Write back; a forced no-op cycle writes nothing
            phase_next = ABLE_Q1;
            done_next = 1'b1;
            unique case (op_reg)
               ABLE_OP_ADDC, ABLE_OP_ANDF: begin
                  // Destination bit picks file or accumulator
                  if (ir_reg[DEST_BIT]) begin
                     fwr_next = '{we: 1'b1, addr: ir_reg[7:0], data: res_reg[7:0]};
                  end else begin
                     acc_next = res_reg[7:0];
                  end
                  flg_next = flg_res_reg;
               end
               ABLE_OP_ANDL: begin
                  // Literal AND always lands in the accumulator
                  acc_next = res_reg[7:0];
                  flg_next = flg_res_reg;
               end
               ABLE_OP_BCLR, ABLE_OP_BSET: begin
                  // Read-modify-write of the whole byte
                  fwr_next = '{we: 1'b1, addr: ir_reg[7:0], data: res_reg[7:0]};
               end
               ABLE_OP_BTSZ, ABLE_OP_NONE: ;
            endcase
         end
      endcase
   end

   // State registers
   // Reset loads constants only; the core restarts in decode with no skip armed
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_reg <= ABLE_Q1;
         op_reg <= ABLE_OP_NONE;
         ir_reg <= 16'h0000;
         opnd_reg <= 8'h00;
         res_reg <= 9'h000;
         flg_res_reg <= FLG_RST;
         acc_reg <= ACC_RST;
         flg_reg <= FLG_RST;
         skip_pend_reg <= 1'b0;
         skip_reg <= 1'b0;
         fwr_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         op_reg <= op_next;
         ir_reg <= ir_next;
         opnd_reg <= opnd_next;
         res_reg <= res_next;
         flg_res_reg <= flg_res_next;
         acc_reg <= acc_next;
         flg_reg <= flg_next;
         skip_pend_reg <= skip_pend_next;
         skip_reg <= skip_next;
         fwr_reg <= fwr_next;
         done_reg <= done_next;
      end
   end

   // Every output comes straight from a flip-flop
   assign working_accumulator = acc_reg;
   assign flags = flg_reg;
   assign phase = phase_reg;
   assign skip_cycle = skip_reg;
   assign file_wr = fwr_reg;
   assign instr_done = done_reg;

   // Checks: every property is cut off while reset is low
   // A bit test that finds its bit clear
   sequence s_btsz_clear;
      phase_reg == ABLE_Q3 && op_reg == ABLE_OP_BTSZ && (opnd_reg & bmask) == 8'h00;
   endsequence

   // The whole forced no-op cycle: four phases of skip with no operation
   sequence s_forced_cycle;
      ##2 (skip_reg && op_reg == ABLE_OP_NONE) [*4];
   endsequence

   property p_skip_nowrite;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && skip_reg) |=> !fwr_reg.we && $stable(acc_reg) && $stable(flg_reg);
   endproperty
   a_skip_nowrite: assert property (p_skip_nowrite) else $error("skip cycle wrote");

   property p_btsz_skip;
      @(posedge clk) disable iff (!reset_n)
      s_btsz_clear |=> ##2 skip_reg;
   endproperty
   a_btsz_skip: assert property (p_btsz_skip) else $error("clear bit did not skip");

   property p_btsz_noskip;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q3 && op_reg == ABLE_OP_BTSZ && (opnd_reg & bmask) != 8'h00)
         |=> ##2 !skip_reg;
   endproperty
   a_btsz_noskip: assert property (p_btsz_noskip) else $error("set bit skipped");

   property p_cycle4;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q1) |-> ##3 (phase_reg == ABLE_Q4) ##1 done_reg;
   endproperty
   a_cycle4: assert property (p_cycle4) else $error("cycle not four phases");

   property p_add_dest;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && op_reg == ABLE_OP_ADDC && ir_reg[DEST_BIT])
         |=> fwr_reg.we && fwr_reg.data == $past(res_reg[7:0]) && $stable(acc_reg);
   endproperty
   a_add_dest: assert property (p_add_dest) else $error("add file dest wrong");

   property p_andf_acc;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && op_reg == ABLE_OP_ANDF && !ir_reg[DEST_BIT])
         |=> !fwr_reg.we && acc_reg == $past(res_reg[7:0]);
   endproperty
   a_andf_acc: assert property (p_andf_acc) else $error("and acc dest wrong");

   property p_and_flags;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && (op_reg == ABLE_OP_ANDL || op_reg == ABLE_OP_ANDF))
         |=> flg_reg[FLG_C] == $past(flg_reg[FLG_C]) && flg_reg[FLG_OV] == $past(flg_reg[FLG_OV])
            && flg_reg[FLG_DC] == $past(flg_reg[FLG_DC])
            && flg_reg[FLG_Z] == (($past(acc_reg) & $past(opnd_reg)) == 8'h00);
   endproperty
   a_and_flags: assert property (p_and_flags) else $error("and touched flags");

   property p_bit_ops;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && (op_reg == ABLE_OP_BCLR || op_reg == ABLE_OP_BSET))
         |=> fwr_reg.we && $stable(flg_reg)
            && ((fwr_reg.data & $past(bmask)) != 8'h00) == ($past(op_reg) == ABLE_OP_BSET);
   endproperty
   a_bit_ops: assert property (p_bit_ops) else $error("bit op wrong");

   property p_add_zero;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && op_reg == ABLE_OP_ADDC)
         |=> flg_reg[FLG_Z] == ($past(res_reg[7:0]) == 8'h00) && flg_reg[FLG_C] == $past(res_reg[8]);
   endproperty
   a_add_zero: assert property (p_add_zero) else $error("add flags wrong");

   property p_add_sum;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q3 && op_reg == ABLE_OP_ADDC)
         |=> res_reg == {1'b0, $past(acc_reg)} + {1'b0, $past(opnd_reg)}
            + {8'h00, $past(flg_reg[FLG_C])};
   endproperty
   a_add_sum: assert property (p_add_sum) else $error("add sum wrong");

   property p_andl_acc;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && op_reg == ABLE_OP_ANDL)
         |=> !fwr_reg.we && acc_reg == ($past(acc_reg) & $past(opnd_reg));
   endproperty
   a_andl_acc: assert property (p_andl_acc) else $error("literal and wrong");

   // Bit ops leave the other seven bits and the accumulator alone
   property p_bit_keep;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && (op_reg == ABLE_OP_BCLR || op_reg == ABLE_OP_BSET))
         |=> ((fwr_reg.data ^ $past(opnd_reg)) & ~$past(bmask)) == 8'h00
            && fwr_reg.addr == $past(file_addr) && $stable(acc_reg);
   endproperty
   a_bit_keep: assert property (p_bit_keep) else $error("bits not kept");

   // Decode in a skip cycle is forced to a no-op and clears the pending skip
   property p_skip_decode;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q1 && skip_pend_reg)
         |=> skip_reg && op_reg == ABLE_OP_NONE && !skip_pend_reg;
   endproperty
   a_skip_decode: assert property (p_skip_decode) else $error("no forced no-op");

   property p_skip_span;
      @(posedge clk) disable iff (!reset_n)
      s_btsz_clear |=> s_forced_cycle;
   endproperty
   a_skip_span: assert property (p_skip_span) else $error("skip cycle cut short");

   // A test or a no-op, forced or unknown, writes nothing at all
   property p_none_nowrite;
      @(posedge clk) disable iff (!reset_n)
      (phase_reg == ABLE_Q4 && (op_reg == ABLE_OP_NONE || op_reg == ABLE_OP_BTSZ))
         |=> !fwr_reg.we && $stable(acc_reg) && $stable(flg_reg);
   endproperty
   a_none_nowrite: assert property (p_none_nowrite) else $error("no-op wrote");

   property p_done_q1;
      @(posedge clk) disable iff (!reset_n)
      done_reg |-> phase_reg == ABLE_Q1 && $past(phase_reg) == ABLE_Q4;
   endproperty
   a_done_q1: assert property (p_done_q1) else $error("done out of phase");
endmodule // able_exec
`default_nettype wire
